// *** shared/fsr_regs.svh ***
/*
 * constants of the forward-queue retransmit block: depth, widths, reset values.
 * assumes inclusion by bare name from any file that needs them.
 */
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH

`define FSR_DEPTH 512
`define FSR_DATA_W 32
`define FSR_PTR_W 9
`define FSR_CNT_W 10
`define FSR_MIN_PAST 2
`define FSR_AE_DEFAULT 8
`define FSR_AF_DEFAULT 8

`endif

// *** shared/fsr_pkg.sv ***
/*
 * types shared by the forward-queue retransmit block.
 * assumes fsr_regs.svh is on the include path.
 */
`include "fsr_regs.svh"
`default_nettype none

package fsr_pkg;
	typedef enum logic [1:0] {
		FSR_NORMAL = 2'b01,
		FSR_MARKED = 2'b10
	} fsr_mode_t;
endpackage

`default_nettype wire

// *** hw/fsr_sync2.sv ***
/*
 * two-flop synchroniser for a single level.
 * assumes the input comes from another clock domain or a pin.
 */
`default_nettype none

module fsr_sync2 (
	input wire logic clock,
	input wire logic nrst,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} fsr_sync_st_t;

	fsr_sync_st_t st_ff;
	fsr_sync_st_t nxt_st;

	always_comb begin
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.s2;
endmodule

`default_nettype wire

// *** hw/fsr_store.sv ***
/*
 * flip-flop word store with one write port and one indexed read port.
 * assumes write index and data are on the same clock.
 */
`include "fsr_regs.svh"
`default_nettype none

module fsr_store #(
	parameter int DEPTH = `FSR_DEPTH,
	parameter int DW = `FSR_DATA_W,
	parameter int AW = `FSR_PTR_W
) (
	input wire logic clock,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	// no reset: contents are undefined until written, as in a real array
	logic [DW-1:0] mem_ff [DEPTH];

	always_ff @(posedge clock) begin
		if (we) begin
			mem_ff[waddr] <= wdata;
		end
	end

	assign rdata = mem_ff[raddr];
endmodule

`default_nettype wire

// *** hw/fsr_queue.sv ***
/*
 * forward queue with synchronous retransmit: data written at the input side is
 * shifted into an output register; a marked start word may be replayed repeatedly.
 * assumes one clock for both sides (the output-port clock), mark_mode_select and
 * replay_from_marker arrive from processor pins and are synchronised here.
 */
`include "fsr_regs.svh"
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Contract
// - queue holds 512 words of 32 bits, input port to output port.
// - enter retransmit on clock edge with mode select high and output ready.
// - entry edge marks the word in the output register as replay start.
// - stay in retransmit until an edge sees mode select low, then resume.
// - exit from retransmit is allowed at any moment.
// - replay starts on edge with replay high after two reads past mark.
// - replay edge loads marked word into output register; reads continue at once.
// - replay edge copies shadow pointer into current read pointer; the code sets it one past the shadow slot.
// - any number of replays allowed, one per replay pulse.
// - current pointer advances per output load; drives ready and almost-empty.
// - shadow pointer fixed during retransmit; drives input-ready and almost-full.
// - writes remain allowed during retransmit mode.
// - almost-full drops on write storing 512 minus offset words after the mark.
// - input-ready drops after 512 writes counted from the marked word.
// - output-ready reflects new fill level immediately after replay.
// - almost-empty may lag a replay by up to two clock edges.
// - exit edge switches input flags reference from shadow to current pointer.
module fsr_queue
	import fsr_pkg::*;
#(
	parameter int DEPTH = `FSR_DEPTH,
	parameter int DW = `FSR_DATA_W,
	parameter int AW = `FSR_PTR_W,
	parameter int CW = `FSR_CNT_W
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic write_enable,
	input wire logic [DW-1:0] write_data,
	input wire logic read_enable,
	input wire logic mark_mode_select,
	input wire logic replay_from_marker,
	input wire logic [CW-1:0] almost_full_offset,
	input wire logic [CW-1:0] almost_empty_offset,
	output logic [DW-1:0] read_data,
	output logic output_ready_flag,
	output logic output_almost_empty_flag,
	output logic input_ready_flag,
	output logic input_almost_full_flag,
	output logic retransmit_active
);
	//////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		fsr_mode_t mode;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] cur_ptr;
		logic [AW-1:0] shadow_ptr;
		logic [DW-1:0] out_word;
		logic out_valid;
		logic [1:0] past_cnt;
		logic [CW-1:0] ae_lvl_d1;
		logic [CW-1:0] ae_lvl_d2;
		logic ae_ff;
		logic ir_ff;
		logic af_ff;
	} fsr_state_t;

	fsr_state_t st_ff;
	fsr_state_t nxt_st;

	logic mode_sel_s;
	logic replay_s;
	logic [DW-1:0] store_rdata;
	logic store_we;
	logic [AW-1:0] rd_addr;

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers and storage

	fsr_sync2 u_sync_mode (
		.clock(clock),
		.nrst(nrst),
		.d(mark_mode_select),
		.q(mode_sel_s)
	);

	fsr_sync2 u_sync_replay (
		.clock(clock),
		.nrst(nrst),
		.d(replay_from_marker),
		.q(replay_s)
	);

	fsr_store #(
		.DEPTH(DEPTH),
		.DW(DW),
		.AW(AW)
	) u_store (
		.clock(clock),
		.we(store_we),
		.waddr(st_ff.wr_ptr),
		.wdata(write_data),
		.raddr(rd_addr),
		.rdata(store_rdata)
	);

	// words held in the array between a read reference and the write pointer;
	// a full queue is told apart from empty by the stored ready flag
	function automatic logic [CW-1:0] fsr_fill(input logic [AW-1:0] wp,
			input logic [AW-1:0] rp, input logic full);
		logic [CW-1:0] diff;
		diff = CW'(wp) - CW'(rp);
		diff = {1'b0, diff[AW-1:0]};
		if (full && diff == '0) begin
			diff = CW'(DEPTH);
		end
		return diff;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// next state

	logic [AW-1:0] in_ref;
	logic [CW-1:0] in_fill;
	logic [CW-1:0] out_fill;
	logic [CW-1:0] nxt_in_fill;
	logic do_write;
	logic load_out;
	logic replay;
	logic [AW-1:0] wr_after;

	always_comb begin
		nxt_st = st_ff;
		replay = 1'b0;
		load_out = 1'b0;
		// a plain load takes the word at cur_ptr, which then steps past it
		rd_addr = st_ff.cur_ptr;

		// input flags follow the shadow pointer while marked, else the current one
		in_ref = (st_ff.mode == FSR_MARKED) ? st_ff.shadow_ptr : st_ff.cur_ptr;
		in_fill = fsr_fill(st_ff.wr_ptr, in_ref, !st_ff.ir_ff);
		do_write = write_enable && st_ff.ir_ff;
		store_we = do_write;
		wr_after = do_write ? st_ff.wr_ptr + AW'(1) : st_ff.wr_ptr;
		nxt_st.wr_ptr = wr_after;

		case (st_ff.mode)
			FSR_NORMAL: begin
				if (mode_sel_s && st_ff.out_valid) begin
					nxt_st.mode = FSR_MARKED;
					// the word in the output register sits one slot behind cur_ptr
					nxt_st.shadow_ptr = st_ff.cur_ptr - AW'(1);
					nxt_st.past_cnt = '0;
				end
			end
			FSR_MARKED: begin
				if (!mode_sel_s) begin
					nxt_st.mode = FSR_NORMAL;
				end else if (replay_s && st_ff.past_cnt >= 2'(`FSR_MIN_PAST)) begin
					replay = 1'b1;
				end
			end
			default: begin
				nxt_st.mode = FSR_NORMAL;
			end
		endcase

		// replay_s outside marked mode never reaches here
		if (replay) begin
			// the marked word sits at the shadow slot; reading resumes one past it
			rd_addr = st_ff.shadow_ptr;
			nxt_st.cur_ptr = st_ff.shadow_ptr + AW'(1);
			load_out = 1'b1;
			nxt_st.out_valid = 1'b1;
			nxt_st.past_cnt = '0;
		end else begin
			out_fill = fsr_fill(st_ff.wr_ptr, st_ff.cur_ptr,
				st_ff.wr_ptr == st_ff.cur_ptr && !st_ff.ir_ff
				&& st_ff.mode == FSR_NORMAL);
			if ((!st_ff.out_valid || read_enable) && out_fill != '0) begin
				load_out = 1'b1;
				nxt_st.cur_ptr = st_ff.cur_ptr + AW'(1);
				nxt_st.out_valid = 1'b1;
				if (st_ff.mode == FSR_MARKED && st_ff.out_valid
						&& st_ff.past_cnt != 2'(`FSR_MIN_PAST)) begin
					nxt_st.past_cnt = st_ff.past_cnt + 2'd1;
				end
			end else if (read_enable) begin
				nxt_st.out_valid = 1'b0;
			end
		end

		// output ready is the output register itself, so it tracks a replay at once
		nxt_st.out_word = load_out ? store_rdata : st_ff.out_word;

		// input-side flags use the reference that holds after this edge
		nxt_in_fill = fsr_fill(wr_after,
			(nxt_st.mode == FSR_MARKED) ? nxt_st.shadow_ptr : nxt_st.cur_ptr,
			!st_ff.ir_ff && !do_write && in_ref == ((nxt_st.mode == FSR_MARKED)
			? nxt_st.shadow_ptr : nxt_st.cur_ptr));
		if (do_write && in_fill == CW'(DEPTH - 1)) begin
			nxt_in_fill = CW'(DEPTH);
		end
		nxt_st.ir_ff = nxt_in_fill < CW'(DEPTH);
		nxt_st.af_ff = nxt_in_fill < (CW'(DEPTH) - almost_full_offset);

		// almost-empty settles through two stages, hence the lag after a replay
		out_fill = fsr_fill(nxt_st.wr_ptr, nxt_st.cur_ptr, !nxt_st.ir_ff
			&& nxt_st.mode == FSR_NORMAL);
		nxt_st.ae_lvl_d1 = out_fill;
		nxt_st.ae_lvl_d2 = st_ff.ae_lvl_d1;
		nxt_st.ae_ff = st_ff.ae_lvl_d2 > almost_empty_offset;
	end

	//////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '{
				mode: FSR_NORMAL,
				wr_ptr: '0,
				cur_ptr: '0,
				shadow_ptr: '0,
				out_word: '0,
				out_valid: 1'b0,
				past_cnt: '0,
				ae_lvl_d1: '0,
				ae_lvl_d2: '0,
				ae_ff: 1'b0,
				ir_ff: 1'b1,
				af_ff: 1'b1
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign read_data = st_ff.out_word;
	assign output_ready_flag = st_ff.out_valid;
	assign output_almost_empty_flag = st_ff.ae_ff;
	assign input_ready_flag = st_ff.ir_ff;
	assign input_almost_full_flag = st_ff.af_ff;
	assign retransmit_active = st_ff.mode[1];
endmodule

`default_nettype wire

// *** verif/fsr_proc_model.sv ***
/* processor pins driving mode select and replay.
assumes requests from the bench, one clock. */
`default_nettype none
module fsr_proc_model (
	input wire logic clock,
	input wire logic mode_req,
	input wire logic replay_req,
	output logic mark_mode_select,
	output logic replay_from_marker
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		mark_mode_select = 1'b0;
		replay_from_marker = 1'b0;
	end
	// the pin drops between passes, so a held request gives a pulse every second clock
	always @(posedge clock) begin
		mark_mode_select <= #1 mode_req;
		replay_from_marker <= #1 replay_req & ~replay_from_marker;
	end
endmodule
`default_nettype wire

// *** verif/fsr_queue_chk.sv ***
/* port assertions of the retransmit queue.
assumes bind into fsr_queue, one clock. */
`default_nettype none
module fsr_queue_chk #(parameter int DW = 32) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic write_enable,
	input wire logic read_enable,
	input wire logic mark_mode_select,
	input wire logic [DW-1:0] read_data,
	input wire logic output_ready_flag,
	input wire logic output_almost_empty_flag,
	input wire logic input_ready_flag,
	input wire logic input_almost_full_flag,
	input wire logic retransmit_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);
	sequence s_sel_low;
		!mark_mode_select [*4];
	endsequence
	a_entry_cause: assert property ($rose(retransmit_active) |-> $past(mark_mode_select, 3))
		else $error("mode entered without select");
	a_entry_ready: assert property ($rose(retransmit_active) |-> $past(output_ready_flag))
		else $error("mode entered while output empty");
	a_exit_low: assert property (s_sel_low |=> !retransmit_active)
		else $error("mode kept after select low");
	a_write_shows: assert property (write_enable && input_ready_flag && !output_ready_flag
		|=> ##1 output_ready_flag)
		else $error("written word not shown");
	a_data_hold: assert property (output_ready_flag && !read_enable && !retransmit_active
		|=> $stable(read_data))
		else $error("output changed without read");
	a_full_afull: assert property (!input_ready_flag |-> !input_almost_full_flag)
		else $error("full without almost full");
	a_empty_ae: assert property (!output_ready_flag [*3] |-> !output_almost_empty_flag)
		else $error("empty but not almost empty");
	a_mode_hold: assert property (retransmit_active && $past(retransmit_active)
		|-> !$rose(input_ready_flag) && !$rose(input_almost_full_flag))
		else $error("input flags freed in mode");
endmodule
bind fsr_queue fsr_queue_chk #(.DW(DW)) u_fsr_queue_chk (.clock(clock), .nrst(nrst),
	.write_enable(write_enable), .read_enable(read_enable),
	.mark_mode_select(mark_mode_select), .read_data(read_data),
	.output_ready_flag(output_ready_flag), .output_almost_empty_flag(output_almost_empty_flag),
	.input_ready_flag(input_ready_flag), .input_almost_full_flag(input_almost_full_flag),
	.retransmit_active(retransmit_active));
`default_nettype wire

// *** verif/fsr_queue_tb.sv ***
/* self-checking bench of the retransmit queue.
assumes offsets of 8 and the processor model. */
`default_nettype none
module fsr_queue_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic write_enable = 1'b0;
	logic read_enable = 1'b0;
	logic mode_req = 1'b0;
	logic replay_req = 1'b0;
	logic [31:0] write_data = 32'h0;
	logic [31:0] read_data;
	logic mark_mode_select, replay_from_marker, output_ready_flag, output_almost_empty_flag;
	logic input_ready_flag, input_almost_full_flag, retransmit_active;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;
	always #2 clock = ~clock;
	fsr_queue u_fsr_queue (.clock(clock), .nrst(nrst), .write_enable(write_enable),
		.write_data(write_data), .read_enable(read_enable),
		.mark_mode_select(mark_mode_select), .replay_from_marker(replay_from_marker),
		.almost_full_offset(10'h008), .almost_empty_offset(10'h008), .read_data(read_data),
		.output_ready_flag(output_ready_flag), .output_almost_empty_flag(output_almost_empty_flag),
		.input_ready_flag(input_ready_flag), .input_almost_full_flag(input_almost_full_flag),
		.retransmit_active(retransmit_active));
	fsr_proc_model u_fsr_proc_model (.clock(clock), .mode_req(mode_req),
		.replay_req(replay_req), .mark_mode_select(mark_mode_select),
		.replay_from_marker(replay_from_marker));
	//////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [31:0] base, input int n);
		for (int i = 0; i < n; i++) begin
			write_enable = 1'b1;
			write_data = base + i;
			tick(1);
		end
		write_enable = 1'b0;
	endtask
	task automatic rd(input int n);
		read_enable = 1'b1;
		tick(n);
		read_enable = 1'b0;
	endtask
	// pin synchroniser adds two edges, so allow a few before looking
	task automatic pulse();
		replay_req = 1'b1;
		tick(1);
		replay_req = 1'b0;
		tick(4);
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			wrap_up();
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(5);
		chk("rst", {output_ready_flag, input_ready_flag, input_almost_full_flag,
			output_almost_empty_flag}, 4'h6);
		nrst = 1'b1;
		tick(1);
		wr(32'h100, 6);
		tick(2);
		chk("first", read_data, 32'h100);
		chk("ae_lo", output_almost_empty_flag, 1'b0);
		rd(2);
		chk("after2", read_data, 32'h102);
		pulse();
		chk("idle", read_data, 32'h102);
		mode_req = 1'b1;
		tick(5);
		chk("enter", retransmit_active, 1'b1);
		rd(3);
		chk("past", read_data, 32'h105);
		pulse();
		chk("replay", read_data, 32'h102);
		chk("orb", output_ready_flag, 1'b1);
		rd(1);
		chk("cont", read_data, 32'h103);
		rd(1);
		pulse();
		chk("again", read_data, 32'h102);
		pulse();
		chk("early", read_data, 32'h102);
		wr(32'h200, 499);
		tick(1);
		chk("af_hi", input_almost_full_flag, 1'b1);
		wr(32'h400, 1);
		tick(1);
		chk("af_lo", input_almost_full_flag, 1'b0);
		wr(32'h500, 7);
		tick(1);
		chk("ir_hi", input_ready_flag, 1'b1);
		wr(32'h600, 1);
		tick(1);
		chk("ir_lo", input_ready_flag, 1'b0);
		mode_req = 1'b0;
		tick(5);
		chk("exit", retransmit_active, 1'b0);
		rd(2);
		tick(2);
		chk("ir_back", input_ready_flag, 1'b1);
		chk("resume", read_data, 32'h104);
		chk("ae", output_almost_empty_flag, 1'b1);
		wrap_up();
	end
endmodule
`default_nettype wire
